// ==== hw/ifc_pkg.sv ====
// Constants and types shared by the IF frequency counter files
package ifc_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned GATE_8_MS = 8;
  localparam int unsigned GATE_32_MS = 32;
  localparam int unsigned GATE_128_MS = 128;
  localparam int unsigned TICK_CYC = TICK_MS * CYC_PER_MS;
  localparam int unsigned GATE_8_CYC = GATE_8_MS * CYC_PER_MS;
  localparam int unsigned GATE_32_CYC = GATE_32_MS * CYC_PER_MS;
  localparam int unsigned GATE_128_CYC = GATE_128_MS * CYC_PER_MS;

  // Widths
  localparam int TICK_W = 14;
  localparam int GATE_W = 21;
  localparam int COUNT_W = 19;
  localparam int ADDR_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0] MODE_IDX = 8'hF4;
  localparam logic [7:0] HIGH_IDX = 8'hF5;
  localparam logic [7:0] MID_IDX = 8'hF6;
  localparam logic [7:0] LOW_IDX = 8'hF7;

  // Mode register fields
  localparam int JUDGE_BIT = 7;
  localparam int START_BIT = 6;
  localparam int CLEAR_BIT = 5;
  localparam int GATE_LSB = 2;
  localparam int SEL_LSB = 0;
  localparam int SEL_EN_BIT = 1;
  localparam int SEL_AM_BIT = 0;
  // High data register field
  localparam int OVF_BIT = 3;

  // Reset values, count maximum and last prescaler step
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [COUNT_W-1:0] COUNT_RST = 19'h00000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 19'h7FFFF;
  localparam logic [1:0] PRE_LAST = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    GATE_8 = 2'h0,
    GATE_32 = 2'h1,
    GATE_128 = 2'h2,
    GATE_SOFT = 2'h3
  } ifc_gate_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_OPEN = 2'b11,
    ST_SOFT = 2'b10
  } ifc_state_t;

endpackage : ifc_pkg

// ==== hw/ifc_edge_sync.sv ====
// Two-flop synchroniser for one IF pin, with a delayed copy for edges
`timescale 1ns/100ps
module ifc_edge_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pin
  input wire logic pin_in,
  // Synchronised level and its previous value
  output logic lvl,
  output logic lvl_prev
);

  logic meta;

  // First flop feeds only the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta <= 1'b0;
      lvl <= 1'b0;
      lvl_prev <= 1'b0;
    end else begin
      meta <= pin_in;
      lvl <= meta;
      lvl_prev <= lvl;
    end
  end

endmodule : ifc_edge_sync

// ==== hw/ifc_counter.sv ====
// IF frequency counter with AXI4-Lite register access
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ifc_counter #(
  parameter int unsigned TICK_CYC = ifc_pkg::TICK_CYC,
  parameter int unsigned GATE_8_CYC = ifc_pkg::GATE_8_CYC,
  parameter int unsigned GATE_32_CYC = ifc_pkg::GATE_32_CYC,
  parameter int unsigned GATE_128_CYC = ifc_pkg::GATE_128_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [ifc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ifc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // IF input pins
  input wire logic fm_if_input,
  input wire logic am_if_input
);

  localparam logic [1:0] IDX_MODE = 2'h0;
  localparam logic [1:0] IDX_HIGH = 2'h1;
  localparam logic [1:0] IDX_MID = 2'h2;
  localparam logic [1:0] IDX_LOW = 2'h3;

  // Returns {hit, index}; used by both read and write paths
  function automatic logic [2:0] ifc_decode(input logic [ifc_pkg::ADDR_W-1:0] a);
    logic [9:0] w;
    w = a[ifc_pkg::ADDR_W-1:2];
    if (w == {2'h0, ifc_pkg::MODE_IDX}) ifc_decode = {1'b1, IDX_MODE};
    else if (w == {2'h0, ifc_pkg::HIGH_IDX}) ifc_decode = {1'b1, IDX_HIGH};
    else if (w == {2'h0, ifc_pkg::MID_IDX}) ifc_decode = {1'b1, IDX_MID};
    else if (w == {2'h0, ifc_pkg::LOW_IDX}) ifc_decode = {1'b1, IDX_LOW};
    else ifc_decode = 3'h0;
  endfunction : ifc_decode

  // Register state
  logic judge_flag;
  logic count_start_bit;
  ifc_pkg::ifc_gate_t gate_time_field;
  logic [1:0] input_select_field;
  logic [ifc_pkg::COUNT_W-1:0] count_value_bits;
  logic overflow_flag;
  ifc_pkg::ifc_state_t state;
  ifc_pkg::ifc_state_t next_state;
  logic [ifc_pkg::TICK_W-1:0] tick_cnt;
  logic [ifc_pkg::GATE_W-1:0] gate_left;
  logic [1:0] pre;
  logic gate_was;

  // Bus state
  logic aw_held;
  logic w_held;
  logic [ifc_pkg::ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane0_q;

  // Write decode
  logic do_wr;
  logic [2:0] wr_dec;
  logic wr_mode;
  logic clr_pulse;
  logic start_rise;
  assign do_wr = aw_held && w_held && !s_axi_bvalid;
  assign wr_dec = ifc_decode(aw_addr_q);
  assign wr_mode = do_wr && w_lane0_q && wr_dec[2] && wr_dec[1:0] == IDX_MODE;
  assign clr_pulse = wr_mode && w_data_q[ifc_pkg::CLEAR_BIT];
  assign start_rise = wr_mode && w_data_q[ifc_pkg::START_BIT] && !count_start_bit;

  // Read decode
  logic rd_take;
  logic [2:0] rd_dec;
  logic rd_mode;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_dec = ifc_decode(s_axi_araddr);
  assign rd_mode = rd_take && rd_dec[2] && rd_dec[1:0] == IDX_MODE;

  // Tick and gate timing
  logic tick;
  logic gate_open;
  logic fixed_busy;
  logic expire;
  logic [ifc_pkg::GATE_W-1:0] gate_load;
  assign tick = tick_cnt == ifc_pkg::TICK_W'(TICK_CYC - 1);
  assign gate_open = state == ifc_pkg::ST_OPEN || state == ifc_pkg::ST_SOFT;
  assign fixed_busy = state == ifc_pkg::ST_WAIT || state == ifc_pkg::ST_OPEN;
  assign expire = state == ifc_pkg::ST_OPEN && gate_left == '0 && count_start_bit;

  always_comb begin
    unique case (gate_time_field)
      ifc_pkg::GATE_8: gate_load = ifc_pkg::GATE_W'(GATE_8_CYC - 1);
      ifc_pkg::GATE_32: gate_load = ifc_pkg::GATE_W'(GATE_32_CYC - 1);
      ifc_pkg::GATE_128: gate_load = ifc_pkg::GATE_W'(GATE_128_CYC - 1);
      ifc_pkg::GATE_SOFT: gate_load = '0;
    endcase
  end

  // Pin synchronisers
  logic [1:0] pin_raw;
  logic [1:0] pin_lvl;
  logic [1:0] pin_prev;
  logic [1:0] pin_evt;
  assign pin_raw = {am_if_input, fm_if_input};

  for (genvar g = 0; g < 2; g++) begin : g_pin
    ifc_edge_sync u_sync (
      .mclk(mclk),
      .rst(rst),
      .pin_in(pin_raw[g]),
      .lvl(pin_lvl[g]),
      .lvl_prev(pin_prev[g])
    );
    // High at the opening cycle counts as an edge; closing adds nothing
    assign pin_evt[g] = gate_open && pin_lvl[g] && !(pin_prev[g] && gate_was);
  end

  logic sel_evt;
  logic cnt_evt;
  assign sel_evt = input_select_field[ifc_pkg::SEL_EN_BIT]
    && (input_select_field[ifc_pkg::SEL_AM_BIT] ? pin_evt[1] : pin_evt[0]);
  assign cnt_evt = sel_evt
    && (input_select_field[ifc_pkg::SEL_AM_BIT] || pre == ifc_pkg::PRE_LAST);

  // Free-running 1 kHz tick from the system clock
  always_ff @(posedge mclk) begin
    if (rst || tick) tick_cnt <= '0;
    else tick_cnt <= tick_cnt + 1'b1;
  end

  // Gate state machine
  always_comb begin
    next_state = state;
    unique case (state)
      ifc_pkg::ST_IDLE: begin
        if (start_rise && w_data_q[ifc_pkg::GATE_LSB +: 2] != ifc_pkg::GATE_SOFT)
          next_state = ifc_pkg::ST_WAIT;
        else if (count_start_bit && gate_time_field == ifc_pkg::GATE_SOFT)
          next_state = ifc_pkg::ST_SOFT;
      end
      ifc_pkg::ST_WAIT: begin
        if (!count_start_bit) next_state = ifc_pkg::ST_IDLE;
        else if (tick) next_state = ifc_pkg::ST_OPEN;
      end
      ifc_pkg::ST_OPEN: begin
        if (!count_start_bit || gate_left == '0) next_state = ifc_pkg::ST_IDLE;
      end
      ifc_pkg::ST_SOFT: begin
        if (!count_start_bit || gate_time_field != ifc_pkg::GATE_SOFT)
          next_state = ifc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ifc_pkg::ST_IDLE;
      gate_was <= 1'b0;
    end else begin
      state <= next_state;
      gate_was <= gate_open;
    end
  end

  // Gate length counter, loaded at the tick so the open time is exact
  always_ff @(posedge mclk) begin
    if (rst) gate_left <= '0;
    else if (state == ifc_pkg::ST_WAIT && tick) gate_left <= gate_load;
    else if (state == ifc_pkg::ST_OPEN && gate_left != '0) gate_left <= gate_left - 1'b1;
  end

  // Mode register fields; start drops when a fixed gate ends
  always_ff @(posedge mclk) begin
    if (rst) begin
      count_start_bit <= 1'b0;
      gate_time_field <= ifc_pkg::GATE_8;
      input_select_field <= ifc_pkg::SEL_RST;
    end else if (wr_mode) begin
      count_start_bit <= w_data_q[ifc_pkg::START_BIT];
      gate_time_field <= ifc_pkg::ifc_gate_t'(w_data_q[ifc_pkg::GATE_LSB +: 2]);
      input_select_field <= w_data_q[ifc_pkg::SEL_LSB +: 2];
    end else if (expire) begin
      count_start_bit <= 1'b0;
    end
  end

  // Judge flag; the set wins over every clear
  always_ff @(posedge mclk) begin
    if (rst) judge_flag <= 1'b0;
    else if (start_rise) judge_flag <= 1'b1;
    else if (expire) judge_flag <= 1'b0;
    else if (state == ifc_pkg::ST_SOFT && wr_mode
      && w_data_q[ifc_pkg::GATE_LSB +: 2] != ifc_pkg::GATE_SOFT) judge_flag <= 1'b0;
    else if (rd_mode && !fixed_busy) judge_flag <= 1'b0;
  end

  // FM divide-by-four prescaler
  always_ff @(posedge mclk) begin
    if (rst || clr_pulse) pre <= '0;
    else if (sel_evt && !input_select_field[ifc_pkg::SEL_AM_BIT]) pre <= pre + 1'b1;
  end

  // Count and overflow
  always_ff @(posedge mclk) begin
    if (rst || clr_pulse) count_value_bits <= ifc_pkg::COUNT_RST;
    else if (cnt_evt) count_value_bits <= count_value_bits + 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (rst) overflow_flag <= 1'b0;
    else if (cnt_evt && count_value_bits == ifc_pkg::COUNT_MAX) overflow_flag <= 1'b1;
    else if (clr_pulse) overflow_flag <= 1'b0;
  end

  // AXI write channels, taken in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end else if (do_wr) begin
        w_held <= 1'b0;
      end
    end
  end

  // Data registers accept a write with OKAY but keep their contents
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ifc_pkg::RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_dec[2] ? ifc_pkg::RESP_OKAY : ifc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // AXI read
  logic [7:0] rd_val;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    unique case (rd_dec[1:0])
      IDX_MODE: rd_val = {judge_flag, count_start_bit, 2'b00, gate_time_field,
        input_select_field};
      IDX_HIGH: rd_val = {4'h0, overflow_flag, count_value_bits[18:16]};
      IDX_MID: rd_val = count_value_bits[15:8];
      IDX_LOW: rd_val = count_value_bits[7:0];
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ifc_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_dec[2] ? {24'h000000, rd_val} : 32'h00000000;
      s_axi_rresp <= rd_dec[2] ? ifc_pkg::RESP_OKAY : ifc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  ro_data_a: assert property (
    do_wr && wr_dec[1:0] != IDX_MODE && !cnt_evt |=> $stable(count_value_bits)
      && $stable(overflow_flag)) else $error("data register write changed count");
  mid_layout_a: assert property (
    rd_take && rd_dec == {1'b1, IDX_MID}
      |=> s_axi_rdata == {24'h000000, $past(count_value_bits[15:8])})
    else $error("mid register layout wrong");
  ovf_bit_a: assert property (
    rd_take && rd_dec == {1'b1, IDX_HIGH}
      |=> s_axi_rdata[7:3] == {4'h0, $past(overflow_flag)})
    else $error("high register overflow bit wrong");
  tick_align_a: assert property (
    state == ifc_pkg::ST_WAIT && count_start_bit && !tick |=> state != ifc_pkg::ST_OPEN)
    else $error("gate opened off the tick");
  soft_open_a: assert property (
    state == ifc_pkg::ST_IDLE && count_start_bit && gate_time_field == ifc_pkg::GATE_SOFT
      && !wr_mode |=> state == ifc_pkg::ST_SOFT) else $error("soft gate did not open");
  judge_set_a: assert property (
    start_rise |=> judge_flag && count_start_bit) else $error("judge not set with start");
  judge_clr_a: assert property (
    expire && !start_rise |=> !judge_flag ##1 state == ifc_pkg::ST_IDLE || judge_flag)
    else $error("judge not cleared at expiry");
  soft_hold_a: assert property (
    judge_flag && state == ifc_pkg::ST_SOFT && !rd_mode && !wr_mode |=> judge_flag)
    else $error("judge cleared in soft gate");
  count_gate_a: assert property (
    !gate_open && !clr_pulse |=> $stable(count_value_bits))
    else $error("count moved with gate closed");
  fm_div_a: assert property (
    sel_evt && !input_select_field[ifc_pkg::SEL_AM_BIT] && pre != ifc_pkg::PRE_LAST
      && !clr_pulse |=> $stable(count_value_bits)) else $error("fm count not divided by four");
  ovf_set_a: assert property (
    cnt_evt && count_value_bits == ifc_pkg::COUNT_MAX && !clr_pulse
      |=> overflow_flag && count_value_bits == ifc_pkg::COUNT_RST)
    else $error("overflow not flagged on wrap");

  fixed_run_c: cover property (state == ifc_pkg::ST_OPEN ##1 state == ifc_pkg::ST_IDLE);
  soft_run_c: cover property (state == ifc_pkg::ST_SOFT && cnt_evt);
  overflow_c: cover property ($rose(overflow_flag));
  judge_read_c: cover property (rd_mode && judge_flag && !fixed_busy);

endmodule : ifc_counter

// ==== tb/ifc_if_source.sv ====
// Square-wave stand-in for the tuner IF outputs on both pins
`timescale 1ns/100ps
module ifc_if_source (
  // Clock
  input wire logic mclk,
  // Half periods in clock cycles; zero holds the pin low
  input wire logic [7:0] fm_half,
  input wire logic [7:0] am_half,
  // IF pins
  output logic fm_if_input,
  output logic am_if_input
);
  logic [7:0] fm_cnt = 8'h00;
  logic [7:0] am_cnt = 8'h00;

  // Both pins run at once so a wrong pin choice shows in the count
  always @(posedge mclk) begin
    if (fm_half == 8'h00) begin
      fm_cnt <= 8'h00;
      fm_if_input <= 1'b0;
    end else if (fm_cnt + 8'h01 >= fm_half) begin
      fm_cnt <= 8'h00;
      fm_if_input <= ~fm_if_input;
    end else begin
      fm_cnt <= fm_cnt + 8'h01;
    end
  end

  always @(posedge mclk) begin
    if (am_half == 8'h00) begin
      am_cnt <= 8'h00;
      am_if_input <= 1'b0;
    end else if (am_cnt + 8'h01 >= am_half) begin
      am_cnt <= 8'h00;
      am_if_input <= ~am_if_input;
    end else begin
      am_cnt <= am_cnt + 8'h01;
    end
  end
endmodule : ifc_if_source

// ==== tb/ifc_counter_tb.sv ====
// Self-checking bench for the IF frequency counter
`timescale 1ns/100ps
module ifc_counter_tb;
  localparam int unsigned TK = 10;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [7:0] fm_half = 8'h00;
  logic [7:0] am_half = 8'h00;
  logic fm_pin;
  logic am_pin;
  int cyc = 0;
  int miscompares = 0;
  int total_checks = 0;

  always #50 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  // Gates scaled with the tick so that gate to tick ratios stay true
  ifc_counter #(.TICK_CYC(TK), .GATE_8_CYC(8 * TK), .GATE_32_CYC(32 * TK),
    .GATE_128_CYC(128 * TK)) uut (
    .mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fm_if_input(fm_pin), .am_if_input(am_pin));

  ifc_if_source src (.mclk(mclk), .fm_half(fm_half), .am_half(am_half),
    .fm_if_input(fm_pin), .am_if_input(am_pin));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  // Edge counts may be one off at either gate end
  function automatic logic [31:0] near(input logic [31:0] seen, input logic [31:0] exp);
    return (seen + 32'h1 >= exp && seen <= exp + 32'h1) ? exp : seen;
  endfunction : near

  function automatic logic [7:0] mode(input logic [1:0] sel, input logic [1:0] gate,
                                      input logic clr, input logic st);
    return {1'b0, st, clr, 1'b0, gate, sel};
  endfunction : mode

  task automatic wr(input logic [7:0] idx, input logic [7:0] data, output logic [1:0] resp);
    @(posedge mclk);
    awaddr <= {2'h0, idx, 2'h0};
    awvalid <= 1'b1;
    wdata <= {24'h000000, data};
    wstrb <= 4'h1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
    @(posedge mclk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic read_count(output logic [31:0] count);
    logic [31:0] h;
    logic [31:0] m;
    logic [31:0] l;
    logic [1:0] r;
    rd(ifc_pkg::HIGH_IDX, h, r);
    rd(ifc_pkg::MID_IDX, m, r);
    rd(ifc_pkg::LOW_IDX, l, r);
    count = {13'h0000, h[2:0], m[7:0], l[7:0]};
  endtask : read_count

  // Select, settle, clear, start, then poll until the gate run ends
  task automatic run(input logic [1:0] sel, input logic [1:0] gate, output logic [31:0] count,
                     output int elapsed, output logic first_judge);
    logic [31:0] d;
    logic [1:0] r;
    int t0;
    int n;
    wr(ifc_pkg::MODE_IDX, mode(sel, gate, 1'b0, 1'b0), r);
    repeat (20) @(posedge mclk);
    wr(ifc_pkg::MODE_IDX, mode(sel, gate, 1'b1, 1'b0), r);
    wr(ifc_pkg::MODE_IDX, mode(sel, gate, 1'b0, 1'b1), r);
    t0 = cyc;
    rd(ifc_pkg::MODE_IDX, d, r);
    first_judge = d[7];
    n = 0;
    while (d[7] !== 1'b0 && n < 1000) begin
      rd(ifc_pkg::MODE_IDX, d, r);
      n++;
    end
    check("run ended", 32'(d[7]), 32'h0);
    elapsed = cyc - t0;
    read_count(count);
  endtask : run

  task automatic test_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(ifc_pkg::MODE_IDX, d, r);
    check("mode after reset", d, 32'h00000000);
    for (int i = 5; i < 8; i++) begin
      rd(8'hF0 + 8'(i), d, r);
      check("count after reset", d, 32'h00000000);
    end
    rd(8'h00, d, r);
    check("unmapped read resp", 32'(r), 32'(ifc_pkg::RESP_SLVERR));
  endtask : test_reset

  task automatic test_am_gates;
    logic [31:0] c;
    int el;
    int g;
    logic j;
    am_half <= 8'h05;
    fm_half <= 8'h02;
    for (int code = 0; code < 3; code++) begin
      g = int'(8 * TK) << (2 * code);
      run(2'h3, 2'(code), c, el, j);
      check("judge at start", 32'(j), 32'h1);
      check("gate length", 32'(el >= g - 4 && el <= g + TK + 12), 32'h1);
      check("am count", near(c, g / 10), g / 10);
    end
  endtask : test_am_gates

  task automatic test_fm;
    logic [31:0] c;
    int el;
    logic j;
    run(2'h2, 2'h2, c, el, j);
    check("fm count", near(c, 32'd80), 32'd80);
  endtask : test_fm

  task automatic test_disabled;
    logic [31:0] c;
    int el;
    logic j;
    run(2'h1, 2'h0, c, el, j);
    check("disabled count", c, 32'h00000000);
  endtask : test_disabled

  task automatic test_soft;
    logic [31:0] c;
    logic [31:0] d;
    logic [1:0] r;
    wr(ifc_pkg::MODE_IDX, mode(2'h3, 2'h3, 1'b0, 1'b0), r);
    repeat (20) @(posedge mclk);
    wr(ifc_pkg::MODE_IDX, mode(2'h3, 2'h3, 1'b1, 1'b0), r);
    wr(ifc_pkg::MODE_IDX, mode(2'h3, 2'h3, 1'b0, 1'b1), r);
    repeat (100) @(posedge mclk);
    wr(ifc_pkg::MODE_IDX, mode(2'h3, 2'h3, 1'b0, 1'b0), r);
    read_count(c);
    check("soft count", near(c, 32'd10), 32'd10);
    rd(ifc_pkg::MODE_IDX, d, r);
    check("judge held", 32'(d[7]), 32'h1);
    rd(ifc_pkg::MODE_IDX, d, r);
    check("judge after read", 32'(d[7]), 32'h0);
    wr(ifc_pkg::MODE_IDX, mode(2'h3, 2'h3, 1'b0, 1'b1), r);
    wr(ifc_pkg::MODE_IDX, mode(2'h3, 2'h0, 1'b0, 1'b0), r);
    rd(ifc_pkg::MODE_IDX, d, r);
    check("judge on fixed code", 32'(d[7]), 32'h0);
  endtask : test_soft

  task automatic test_readonly;
    logic [31:0] v;
    logic [31:0] d;
    logic [1:0] r;
    rd(ifc_pkg::LOW_IDX, v, r);
    wr(ifc_pkg::LOW_IDX, 8'hFF, r);
    check("data write resp", 32'(r), 32'(ifc_pkg::RESP_OKAY));
    rd(ifc_pkg::LOW_IDX, d, r);
    check("low after write", d, v);
    wr(ifc_pkg::HIGH_IDX, 8'h0F, r);
    rd(ifc_pkg::HIGH_IDX, d, r);
    check("high flags", d & 32'h000000F8, 32'h00000000);
    wr(8'h00, 8'h00, r);
    check("unmapped write resp", 32'(r), 32'(ifc_pkg::RESP_SLVERR));
    wr(ifc_pkg::MODE_IDX, mode(2'h3, 2'h0, 1'b1, 1'b0), r);
    read_count(d);
    check("count after clear", d, 32'h00000000);
  endtask : test_readonly

  task automatic results;
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // Whole run is a few thousand cycles; this leaves wide margin
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    results();
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    test_reset();
    test_am_gates();
    test_fm();
    test_disabled();
    test_soft();
    test_readonly();
    results();
  end
endmodule : ifc_counter_tb
